//--- include/ppm_pkg.sv
`default_nettype none
package ppm_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PORT_RESET_NS = 1000;
   localparam int PORT_RESET_CYCLES = (PORT_RESET_NS * CLK_MHZ + 999) / 1000;
   // three sync flops plus one agreement stage before the strap lanes are valid
   localparam int STRAP_SETTLE_CYCLES = 6;
   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
   localparam logic [4:0] IDX_IDENT_WORD_ONE = 5'h02;
   localparam logic [4:0] IDX_IDENT_WORD_TWO = 5'h03;
   localparam logic [4:0] IDX_EXTENDED_STATUS = 5'h0f;
   localparam logic [4:0] IDX_IDENT_WORD_THREE = 5'h10;
   localparam logic [4:0] IDX_EXTENDED_CONTROL = 5'h11;
   localparam logic [4:0] IDX_PORT_CONFIG_ONE = 5'h12;
   localparam logic [4:0] IDX_PORT_CONFIG_TWO = 5'h13;
   localparam logic [4:0] IDX_SYMBOL_ERROR_COUNT = 5'h14;
   localparam logic [4:0] IDX_IRQ_SOURCE = 5'h15;
   localparam logic [4:0] IDX_IRQ_ENABLE = 5'h16;
   localparam logic [4:0] IDX_COMM_STATUS = 5'h17;
   localparam logic [4:0] IDX_GENERAL_STATUS = 5'h18;
   localparam logic [4:0] IDX_EXTERNAL_STATUS = 5'h19;
   localparam logic [4:0] IDX_LINK_FAIL_COUNT = 5'h1a;
   localparam logic [4:0] IDX_SHARED_CONFIG = 5'h1b;
   localparam logic [4:0] IDX_PORT_CONFIG_THREE = 5'h1c;
   // ----------------------------------------------------------------
   // basic control and status fields
   // ----------------------------------------------------------------
   localparam int CTL_RESET_BIT = 15;
   localparam int CTL_LOOPBACK_BIT = 14;
   localparam int CTL_SPEED_LSB_BIT = 13;
   localparam int CTL_NEG_ENABLE_BIT = 12;
   localparam int CTL_STANDBY_BIT = 11;
   localparam int CTL_DETACH_BIT = 10;
   localparam int CTL_NEG_RESTART_BIT = 9;
   localparam int CTL_DUPLEX_BIT = 8;
   localparam int CTL_COL_TEST_BIT = 7;
   localparam int CTL_SPEED_MSB_BIT = 6;
   localparam int CTL_UNIDIR_BIT = 5;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam int STAT_REMOTE_FAULT_BIT = 4;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_JABBER_BIT = 1;
   localparam logic [15:0] STAT_FIXED = 16'h01e1;
   // ----------------------------------------------------------------
   // extended control fields and reset values
   // ----------------------------------------------------------------
   localparam int EXT_MODE_MSB = 14;
   localparam int EXT_MODE_LSB = 11;
   localparam int EXT_LOOP_MSB = 4;
   localparam int EXT_LOOP_LSB = 3;
   localparam logic [3:0] MODE_NORMAL = 4'h3;
   localparam logic [15:0] EXT_CTL_RESET = 16'h1800;
   localparam logic [15:0] SHARED_RESET = 16'h0000;
   // identification words: arbitrary values
   localparam logic [15:0] ID_WORD_ONE = 16'h0a5a;
   localparam logic [15:0] ID_WORD_TWO = 16'h5a50;
   localparam logic [15:0] ID_WORD_THREE = 16'h0001;
   // ----------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_OP = 3'h2,
      ST_PHY = 3'h3,
      ST_REG = 3'h4,
      ST_TA = 3'h5,
      ST_DATA = 3'h6
   } ppm_state_t;
endpackage : ppm_pkg
`default_nettype wire

//--- verilog/ppm_regmem.sv
`default_nettype none
module ppm_regmem
   import ppm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [5:0] waddr_i,
   input wire logic [15:0] wdata_i,
   input wire logic [5:0] raddr_i,
   output logic [15:0] rdata_o
);
   typedef struct packed {
      logic [63:0][15:0] mem;
      logic [15:0] rdata;
   } ppm_mem_t;

   ppm_mem_t st_reg;
   ppm_mem_t st_next;

   always_comb begin
      st_next = st_reg;
      if (we_i) begin
         st_next.mem[waddr_i] = wdata_i;
      end
      st_next.rdata = st_reg.mem[raddr_i];
   end

   // cleared at reset so never-written words read as zero
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata_o = st_reg.rdata;
endmodule : ppm_regmem
`default_nettype wire

//--- verilog/ppm_bank.sv
`default_nettype none
module ppm_bank
   import ppm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic [2:0] phy_addr_strap_i,
   input wire logic [1:0] link_up_i,
   input wire logic [1:0] remote_fault_i,
   input wire logic [1:0] jabber_i,
   output logic [1:0] port_reset_o,
   output logic [1:0] loopback_o,
   output logic [3:0] loop_variant_o,
   output logic [1:0] standby_o,
   output logic [1:0] isolate_o,
   output logic [1:0] normal_req_o,
   output logic [1:0] control_err_o,
   output logic [15:0] shared_config_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // sync lanes: 0 mdc, 1 mdio, 3:2 link, 5:4 fault, 7:6 jabber, 10:8 strap
   typedef struct packed {
      logic [2:0][10:0] sync;
      logic [10:0] flt;
      ppm_state_t state;
      logic [3:0] cnt;
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] idx;
      logic [15:0] shift;
      logic hit;
      logic port;
      logic mdio_out;
      logic mdio_en;
      logic [2:0] strap;
      logic [2:0] settle;
      logic strap_done;
      logic [1:0] ctl_rst;
      logic [1:0] loop;
      logic [1:0] pd;
      logic [1:0] iso;
      logic [1:0] unidir;
      logic [1:0] err;
      logic [1:0] wake;
      logic [1:0][15:0] rst_cnt;
      logic [1:0][15:0] ext;
      logic [1:0][15:0] shared;
      logic [1:0] lh_rf;
      logic [1:0] lh_jab;
      logic [1:0] ll_link;
   } ppm_bank_t;

   ppm_bank_t st_reg;
   ppm_bank_t st_next;
   logic mdc_edge;
   logic bit_in;
   logic wr_now;
   logic [15:0] wr_data;
   logic mem_we;
   logic [15:0] mem_rdata;
   logic [15:0] rd_word;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic port_zero_only(input logic [4:0] idx);
      port_zero_only = (idx == IDX_IDENT_WORD_ONE) || (idx == IDX_IDENT_WORD_TWO) ||
                       (idx == IDX_IDENT_WORD_THREE) || (idx == IDX_SHARED_CONFIG);
   endfunction : port_zero_only

   function automatic logic mem_backed_rw(input logic [4:0] idx);
      mem_backed_rw = (idx == IDX_PORT_CONFIG_ONE) || (idx == IDX_PORT_CONFIG_TWO) ||
                      (idx == IDX_IRQ_ENABLE);
   endfunction : mem_backed_rw

   function automatic logic [15:0] read_word(input ppm_bank_t s, input logic [15:0] mw);
      logic [15:0] w;
      logic p;
      w = 16'h0000;
      p = s.port;
      if (p && port_zero_only(s.idx)) begin
         w = 16'h0000;
      end else begin
         case (s.idx)
            IDX_BASIC_CONTROL: begin
               w[CTL_RESET_BIT] = s.ctl_rst[p];
               w[CTL_LOOPBACK_BIT] = s.loop[p];
               w[CTL_SPEED_LSB_BIT] = SPEED_100[0];
               w[CTL_SPEED_MSB_BIT] = SPEED_100[1];
               w[CTL_NEG_ENABLE_BIT] = 1'b0;
               w[CTL_NEG_RESTART_BIT] = 1'b0;
               w[CTL_DUPLEX_BIT] = 1'b1;
               w[CTL_COL_TEST_BIT] = 1'b0;
               w[CTL_STANDBY_BIT] = s.pd[p];
               w[CTL_DETACH_BIT] = s.iso[p];
               w[CTL_UNIDIR_BIT] = s.unidir[p];
            end
            IDX_BASIC_STATUS: begin
               w = STAT_FIXED;
               w[STAT_REMOTE_FAULT_BIT] = s.lh_rf[p];
               w[STAT_JABBER_BIT] = s.lh_jab[p];
               w[STAT_LINK_BIT] = s.ll_link[p];
            end
            IDX_IDENT_WORD_ONE: w = ID_WORD_ONE;
            IDX_IDENT_WORD_TWO: w = ID_WORD_TWO;
            IDX_IDENT_WORD_THREE: w = ID_WORD_THREE;
            IDX_EXTENDED_CONTROL: w = s.ext[p];
            IDX_SHARED_CONFIG: w = s.shared[0];
            IDX_PORT_CONFIG_THREE: w = s.shared[1];
            default: w = mw;
         endcase
      end
      read_word = w;
   endfunction : read_word

   assign mdc_edge = !st_reg.flt[0] && st_reg.sync[1][0] && st_reg.sync[2][0];
   // mdio taken at the same pipeline depth as the clock edge
   assign bit_in = st_reg.sync[2][1];
   assign wr_now = (st_reg.state == ST_DATA) && mdc_edge && (st_reg.cnt == 4'hf) &&
                   st_reg.hit && (st_reg.op == OP_WRITE);
   assign wr_data = {st_reg.shift[14:0], bit_in};
   assign mem_we = wr_now && mem_backed_rw(st_reg.idx);
   assign rd_word = read_word(st_reg, mem_rdata);

   ppm_regmem u_mem (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .we_i(mem_we),
      .waddr_i({st_reg.port, st_reg.idx}),
      .wdata_i(wr_data),
      .raddr_i({st_reg.port, st_reg.idx}),
      .rdata_o(mem_rdata)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic p;
      logic pd_bad;
      logic iso_bad;
      logic both_new;
      logic rd_clr;
      p = st_reg.port;
      pd_bad = 1'b0;
      iso_bad = 1'b0;
      both_new = 1'b0;
      rd_clr = 1'b0;
      st_next = st_reg;
      st_next.sync = {st_reg.sync[1:0], jabber_i, remote_fault_i, link_up_i, mdio_i, mdc_i,
                      phy_addr_strap_i};
      st_next.sync[0] = {phy_addr_strap_i, jabber_i, remote_fault_i, link_up_i, mdio_i, mdc_i};
      for (int i = 0; i < 11; i++) begin
         if (st_reg.sync[1][i] == st_reg.sync[2][i]) begin
            st_next.flt[i] = st_reg.sync[2][i];
         end
      end
      st_next.err = 2'h0;
      st_next.wake = 2'h0;

      // straps caught once after release, then frozen
      if (!st_reg.strap_done) begin
         st_next.settle = st_reg.settle + 3'h1;
         if (st_reg.settle == 3'(STRAP_SETTLE_CYCLES - 1)) begin
            st_next.strap = st_reg.flt[10:8];
            st_next.strap_done = 1'b1;
         end
      end

      if (mdc_edge) begin
         st_next.cnt = st_reg.cnt + 4'h1;
         case (st_reg.state)
            ST_IDLE: begin
               if (!bit_in) begin
                  st_next.state = ST_START;
               end
            end
            ST_START: begin
               st_next.state = bit_in ? ST_OP : ST_IDLE;
               st_next.cnt = 4'h0;
            end
            ST_OP: begin
               st_next.op = {st_reg.op[0], bit_in};
               if (st_reg.cnt == 4'h1) begin
                  st_next.state = ST_PHY;
                  st_next.cnt = 4'h0;
               end
            end
            ST_PHY: begin
               st_next.phy = {st_reg.phy[3:0], bit_in};
               if (st_reg.cnt == 4'h4) begin
                  st_next.state = ST_REG;
                  st_next.cnt = 4'h0;
               end
            end
            ST_REG: begin
               st_next.idx = {st_reg.idx[3:0], bit_in};
               if (st_reg.cnt == 4'h4) begin
                  st_next.state = ST_TA;
                  st_next.cnt = 4'h0;
                  st_next.hit = (st_reg.phy == 5'h00) ||
                                (st_reg.phy[4:1] == {1'b0, st_reg.strap});
                  st_next.port = (st_reg.phy != 5'h00) && st_reg.phy[0];
               end
            end
            ST_TA: begin
               if (st_reg.cnt == 4'h0) begin
                  if (st_reg.hit && (st_reg.op == OP_READ)) begin
                     st_next.shift = rd_word;
                     st_next.mdio_en = 1'b1;
                     st_next.mdio_out = 1'b0;
                     rd_clr = (st_reg.idx == IDX_BASIC_STATUS);
                  end
               end else begin
                  st_next.state = ST_DATA;
                  st_next.cnt = 4'h0;
                  st_next.mdio_out = st_reg.shift[15];
                  st_next.shift = {st_reg.shift[14:0], 1'b0};
               end
            end
            ST_DATA: begin
               if (st_reg.op == OP_WRITE) begin
                  st_next.shift = wr_data;
               end else begin
                  st_next.mdio_out = st_reg.shift[15];
                  st_next.shift = {st_reg.shift[14:0], 1'b0};
               end
               if (st_reg.cnt == 4'hf) begin
                  st_next.state = ST_IDLE;
                  st_next.mdio_en = 1'b0;
                  st_next.mdio_out = 1'b0;
               end
            end
            default: begin
               st_next.state = ST_IDLE;
               st_next.mdio_en = 1'b0;
            end
         endcase
      end

      // latched flags: a new event wins over the read that clears it
      for (int q = 0; q < 2; q++) begin
         if (rd_clr && (p == q[0])) begin
            st_next.lh_rf[q] = st_reg.flt[4 + q];
            st_next.lh_jab[q] = st_reg.flt[6 + q];
            st_next.ll_link[q] = st_reg.flt[2 + q];
         end else begin
            st_next.lh_rf[q] = st_reg.lh_rf[q] | st_reg.flt[4 + q];
            st_next.lh_jab[q] = st_reg.lh_jab[q] | st_reg.flt[6 + q];
            st_next.ll_link[q] = st_reg.ll_link[q] & st_reg.flt[2 + q];
         end
      end

      if (wr_now) begin
         case (st_reg.idx)
            IDX_BASIC_CONTROL: begin
               if (wr_data[CTL_RESET_BIT]) begin
                  st_next.ctl_rst[p] = 1'b1;
                  st_next.rst_cnt[p] = 16'(PORT_RESET_CYCLES);
               end
               st_next.loop[p] = wr_data[CTL_LOOPBACK_BIT];
               st_next.unidir[p] = wr_data[CTL_UNIDIR_BIT];
               // speed, negotiation, duplex and collision bits are not stored
               both_new = wr_data[CTL_STANDBY_BIT] && wr_data[CTL_DETACH_BIT] &&
                          !st_reg.pd[p] && !st_reg.iso[p];
               pd_bad = wr_data[CTL_STANDBY_BIT] && !st_reg.pd[p] && st_reg.iso[p];
               iso_bad = wr_data[CTL_DETACH_BIT] && !st_reg.iso[p] && st_reg.pd[p];
               st_next.err[p] = pd_bad || iso_bad || both_new;
               if (wr_data[CTL_STANDBY_BIT]) begin
                  if (!pd_bad && !both_new) begin
                     st_next.pd[p] = 1'b1;
                  end
               end else if (st_reg.pd[p]) begin
                  st_next.pd[p] = 1'b0;
                  st_next.wake[p] = st_reg.ext[p][EXT_MODE_MSB:EXT_MODE_LSB] == MODE_NORMAL;
               end
               if (wr_data[CTL_DETACH_BIT]) begin
                  if (!iso_bad && !both_new) begin
                     st_next.iso[p] = 1'b1;
                  end
               end else begin
                  st_next.iso[p] = 1'b0;
               end
            end
            IDX_EXTENDED_CONTROL: st_next.ext[p] = wr_data;
            IDX_SHARED_CONFIG: begin
               if (!(p && port_zero_only(st_reg.idx))) begin
                  st_next.shared[0] = wr_data;
               end
            end
            IDX_PORT_CONFIG_THREE: st_next.shared[1] = wr_data;
            default: st_next.err = st_next.err;
         endcase
      end

      // port reset holds its bit until the count runs out
      for (int q = 0; q < 2; q++) begin
         if (st_reg.ctl_rst[q]) begin
            st_next.rst_cnt[q] = st_reg.rst_cnt[q] - 16'h0001;
            if (st_reg.rst_cnt[q] <= 16'h0001) begin
               st_next.ctl_rst[q] = 1'b0;
               st_next.loop[q] = 1'b0;
               st_next.pd[q] = 1'b0;
               st_next.iso[q] = 1'b0;
               st_next.unidir[q] = 1'b0;
               st_next.ext[q] = EXT_CTL_RESET;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.state <= ST_IDLE;
         st_reg.ext <= {EXT_CTL_RESET, EXT_CTL_RESET};
         st_reg.shared <= {SHARED_RESET, SHARED_RESET};
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign mdio_o = st_reg.mdio_out;
   assign mdio_oe_o = st_reg.mdio_en;
   assign port_reset_o = st_reg.ctl_rst;
   assign loopback_o = st_reg.loop;
   assign loop_variant_o = {st_reg.ext[1][EXT_LOOP_MSB:EXT_LOOP_LSB],
                            st_reg.ext[0][EXT_LOOP_MSB:EXT_LOOP_LSB]};
   assign standby_o = st_reg.pd;
   assign isolate_o = st_reg.iso;
   assign normal_req_o = st_reg.wake;
   assign control_err_o = st_reg.err;
   assign shared_config_o = st_reg.shared[0];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   localparam int RST_HI = PORT_RESET_CYCLES + 1;
   logic wr_ctl0;
   assign wr_ctl0 = wr_now && (st_reg.idx == IDX_BASIC_CONTROL) && !st_reg.port;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence reg_done_s;
      (st_reg.state == ST_REG) && mdc_edge && (st_reg.cnt == 4'h4);
   endsequence
   sequence ta_read_s;
      (st_reg.state == ST_TA) && mdc_edge && (st_reg.cnt == 4'h0) && st_reg.hit &&
      (st_reg.op == OP_READ);
   endsequence

   addr_zero_a: assert property (reg_done_s ##0 (st_reg.phy == 5'h00) |=> st_reg.hit && !st_reg.port)
      else $error("address zero not answered on port zero");
   port_select_a: assert property (reg_done_s ##0 (st_reg.phy == {1'b0, st_reg.strap, 1'b1})
      |=> st_reg.hit && st_reg.port)
      else $error("port one address did not select port one");
   read_drive_a: assert property (ta_read_s |=> mdio_oe_o && !mdio_o)
      else $error("turnaround not driven low on read");
   port_one_ident_a: assert property (st_reg.port && port_zero_only(st_reg.idx) |-> rd_word == 16'h0000)
      else $error("port-zero-only register visible on port one");
   ctl_fixed_a: assert property ((st_reg.idx == IDX_BASIC_CONTROL) |-> rd_word[8] && !rd_word[12] && !rd_word[9] && !rd_word[7] && rd_word[13] && !rd_word[6])
      else $error("fixed control bits read wrong");
   reset_clear_a: assert property ($rose(st_reg.ctl_rst[0]) |-> ##[1:RST_HI] !st_reg.ctl_rst[0])
      else $error("port reset did not clear itself");
   standby_conflict_a: assert property (wr_ctl0 && wr_data[11] && st_reg.iso[0] && !st_reg.pd[0] |=> control_err_o[0] && !standby_o[0])
      else $error("standby while detached not refused");
   detach_conflict_a: assert property (wr_ctl0 && wr_data[10] && st_reg.pd[0] && !st_reg.iso[0] |=> control_err_o[0] && !isolate_o[0])
      else $error("detach in standby not refused");
   standby_enter_a: assert property (wr_ctl0 && wr_data[11] && !wr_data[10] && !st_reg.iso[0] |=> standby_o[0])
      else $error("standby request not taken");
   normal_wake_a: assert property (wr_ctl0 && !wr_data[11] && st_reg.pd[0] && (st_reg.ext[0][14:11] == 4'h3) |=> normal_req_o[0] && !standby_o[0])
      else $error("normal request missing after standby clear");
   latch_high_a: assert property (st_reg.flt[4] |=> st_reg.lh_rf[0])
      else $error("latched-high flag lost its event");
   latch_low_a: assert property (!st_reg.flt[2] |=> !st_reg.ll_link[0])
      else $error("latched-low flag lost its drop");
   strap_fixed_a: assert property (st_reg.strap_done |=> $stable(st_reg.strap))
      else $error("strapped address changed");
endmodule : ppm_bank
`default_nettype wire

//--- test/ppm_host_model.sv
`default_nettype none
// ----------------------------------------------------------------
// management host: frames on mdc/mdio
// ----------------------------------------------------------------
module ppm_host_model (
   input wire logic sys_clk_i,
   input wire logic mdio_o,
   input wire logic mdio_oe_o,
   output logic mdc_o,
   output logic line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b1;
   initial mdc_o = 1'b0;
   // released line carries the host's drv value, which idles high between frames
   assign line_o = mdio_oe_o ? mdio_o : drv;
   // callers only address port zero or port one
   task automatic xfer(input logic [1:0] op, input logic [9:0] adr, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [33:0] v;
      // two idle ones, then the start pattern 0 1
      v = {4'hd, op, adr, ((op == 2'h2) ? 2'h3 : 2'h2), wd};
      for (int i = 33; i >= 0; i--) begin
         @(posedge sys_clk_i);
         mdc_o <= 1'b0;
         drv <= v[i];
         repeat (4) @(posedge sys_clk_i);
         if (i < 16) rd[i] = line_o;
         mdc_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
      end
      drv <= 1'b1;
   endtask : xfer
endmodule : ppm_host_model
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench
   import ppm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, mdc, line, mdio_o, mdio_oe_o;
   logic [2:0] strap = 3'h0;
   logic [1:0] link_up = 2'h3, jab = 2'h0, rf = 2'h0, prst, lpb, stby, iso, nreq, cerr;
   logic [3:0] lvar;
   logic [15:0] shared, rd, w;
   logic [4:0] p0, p1;
   integer seed = 43, failures = 0, checks_done = 0, errs = 0, nreqs = 0;
   ppm_bank i_ppm_bank(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(line),
      .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .phy_addr_strap_i(strap), .link_up_i(link_up),
      .remote_fault_i(rf), .jabber_i(jab), .port_reset_o(prst), .loopback_o(lpb),
      .loop_variant_o(lvar), .standby_o(stby), .isolate_o(iso), .normal_req_o(nreq),
      .control_err_o(cerr), .shared_config_o(shared));
   ppm_host_model i_ppm_host_model(.sys_clk_i(sys_clk_i), .mdio_o(mdio_o),
      .mdio_oe_o(mdio_oe_o), .mdc_o(mdc), .line_o(line));
   initial forever #2 sys_clk_i = ~sys_clk_i;
   // outputs are unknown until the first reset edge, so count only after it
   always @(posedge sys_clk_i) begin
      if (!rst_i) begin
         errs <= errs + cerr[0];
         nreqs <= nreqs + nreq[0];
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
      logic [15:0] x;
      i_ppm_host_model.xfer(OP_WRITE, {p, r}, d, x);
      repeat (4) @(posedge sys_clk_i);
   endtask : wr
   task automatic rdr(input logic [4:0] p, input logic [4:0] r);
      i_ppm_host_model.xfer(OP_READ, {p, r}, 16'hffff, rd);
   endtask : rdr
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      strap = 3'($random(seed));
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      p0 = {1'b0, strap, 1'b0};
      p1 = {1'b0, strap, 1'b1};
      rdr(5'h00, IDX_BASIC_CONTROL);
      chk("ctl reset", 16'h2100, rd);
      for (int k = 0; k < 6; k++) begin
         w = (k == 0) ? 16'h73e0 : (16'($random(seed)) & 16'h73e0);
         wr(k[0] ? p1 : p0, IDX_BASIC_CONTROL, w);
         rdr(k[0] ? p1 : p0, IDX_BASIC_CONTROL);
         chk("ctl", (w & 16'h4020) | 16'h2100, rd);
         chk("loopback", {15'h0, w[14]}, {15'h0, lpb[k[0]]});
      end
      $display("test control done");
      w = 16'($random(seed));
      wr(p0, IDX_SHARED_CONFIG, w);
      chk("shared out", w, shared);
      rdr(p1, IDX_SHARED_CONFIG);
      chk("shared via one", 16'h0, rd);
      wr(p0, IDX_PORT_CONFIG_ONE, w);
      wr(p1, IDX_PORT_CONFIG_ONE, ~w);
      rdr(5'h00, IDX_PORT_CONFIG_ONE);
      chk("cfg zero", w, rd);
      rdr(p1, IDX_PORT_CONFIG_ONE);
      chk("cfg one", ~w, rd);
      wr(p1, IDX_PORT_CONFIG_THREE, w);
      rdr(p0, IDX_PORT_CONFIG_THREE);
      chk("cfg three", w, rd);
      wr(p1, IDX_EXTENDED_CONTROL, 16'h1818);
      chk("loop variant", 16'h3, {14'h0, lvar[3:2]});
      $display("test ports done");
      wr(p0, IDX_BASIC_CONTROL, 16'h2900);
      chk("standby", 16'h1, {15'h0, stby[0]});
      wr(p0, IDX_BASIC_CONTROL, 16'h2d00);
      chk("iso refused", 16'h2, 16'({errs[0], iso[0]}));
      wr(p0, IDX_BASIC_CONTROL, 16'h2100);
      chk("normal req", 16'h1, 16'(nreqs));
      wr(p0, IDX_BASIC_CONTROL, 16'h2500);
      chk("isolate", 16'h1, {15'h0, iso[0]});
      wr(p0, IDX_BASIC_CONTROL, 16'h2d00);
      chk("stby refused", 16'h4, 16'({errs[2:0], stby[0]}));
      wr(p0, IDX_BASIC_CONTROL, 16'hc100);
      chk("soft reset", 16'h1, {15'h0, prst[0]});
      for (int n = 0; n < 400 && prst[0] !== 1'b0; n++) @(posedge sys_clk_i);
      rdr(p0, IDX_BASIC_CONTROL);
      chk("after reset", 16'h2100, rd);
      $display("test modes done");
      jab <= 2'h1;
      rf <= 2'h1;
      link_up <= 2'h2;
      repeat (8) @(posedge sys_clk_i);
      jab <= 2'h0;
      rf <= 2'h0;
      link_up <= 2'h3;
      repeat (8) @(posedge sys_clk_i);
      rdr(p0, IDX_BASIC_STATUS);
      chk("latched", 16'h1, {14'h0, rd[2:1]});
      chk("fault latched", 16'h1, {15'h0, rd[4]});
      rdr(p0, IDX_BASIC_STATUS);
      chk("released", 16'h2, {14'h0, rd[2:1]});
      chk("fault released", 16'h0, {15'h0, rd[4]});
      $display("test latches done");
      print_verdict();
   end
   initial begin
      #200000;
      failures++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
